/* File: hdl/ufc_pkg.sv */
// constants for the uart queue control and interrupt identification block
// assumes a 32-bit ahb-lite bus with one word per register
package ufc_pkg;

  // byte addresses of the registers
  localparam logic [31:0] FIFO_CONTROL_INT_IDENT_ADDR = 32'h5000_1108;
  localparam logic [31:0] EVT_STAT_ADDR = 32'h5000_1180;
  localparam logic [31:0] EVT_MASK_ADDR = 32'h5000_1184;
  localparam logic [31:0] CTRL_ADDR = 32'h5000_1188;
  localparam logic [31:0] LEVEL_ADDR = 32'h5000_118c;

  // write-side field positions of fifo_control_int_ident
  localparam int RX_THR_LSB = 6;
  localparam int TX_THR_LSB = 4;
  localparam int DMA_MODE_BIT = 3;
  localparam int XRST_BIT = 2;
  localparam int RRST_BIT = 1;
  localparam int QUEUES_EN_BIT = 0;

  // read-side values
  localparam logic [1:0] QSTATUS_OFF = 2'h0;
  localparam logic [1:0] QSTATUS_ON = 2'h3;
  localparam logic [1:0] TX_THR_READ = 2'h0;

  // pending interrupt codes
  localparam logic [3:0] CODE_NONE = 4'h1;
  localparam logic [3:0] CODE_TX_EMPTY = 4'h2;
  localparam logic [3:0] CODE_RX_DATA = 4'h4;
  localparam logic [3:0] CODE_LINE = 4'h6;
  localparam logic [3:0] CODE_BUSY = 4'h7;
  localparam logic [3:0] CODE_TIMEOUT = 4'hc;
  localparam logic [3:0] CODE_MODEM = 4'h0;

  // control register bits
  localparam int CTRL_RX_EN = 0;
  localparam int CTRL_TXE_EN = 1;
  localparam int CTRL_LINE_EN = 2;
  localparam int CTRL_MODEM_EN = 3;
  localparam int CTRL_PROG_TXE = 4;
  localparam int CTRL_AUTO_FLOW = 5;
  localparam int CTRL_W = 6;

  // event status and mask bits
  localparam int EV_RX_DATA = 0;
  localparam int EV_TX_EMPTY = 1;
  localparam int EV_LINE = 2;
  localparam int EV_TIMEOUT = 3;
  localparam int EV_MODEM = 4;
  localparam int EV_BUSY = 5;
  localparam int EV_W = 6;

  // reset values
  localparam logic [7:0] FCR_RESET = 8'h00;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;
  localparam logic [EV_W-1:0] MASK_RESET = 6'h00;

  // ahb transfer type bit that marks an active transfer
  localparam int HTRANS_ACTIVE_BIT = 1;

endpackage

/* File: hdl/ufc_level_cmp.sv */
// maps a two-bit threshold selection to a fill level and compares against it
// assumes level counts characters held, 0 to DEPTH
module ufc_level_cmp #(
  parameter int DEPTH = 16,
  parameter int LVL_W = 5,
  parameter bit IS_TX = 1'b0
) (
  // level and selection
  input wire logic [LVL_W-1:0] level,
  input wire logic [1:0] sel,
  input wire logic queues_on,
  // result
  output logic reached
);

  logic [LVL_W-1:0] thr;

  always_comb begin
    if (!IS_TX) begin
      // without queues a single character is the only sensible trigger
      case (queues_on ? sel : 2'h0)
        2'h0: thr = LVL_W'(1);
        2'h1: thr = LVL_W'(DEPTH / 4);
        2'h2: thr = LVL_W'(DEPTH / 2);
        default: thr = LVL_W'(DEPTH - 2);
      endcase
      reached = (level >= thr);
    end else begin
      case (queues_on ? sel : 2'h0)
        2'h0: thr = LVL_W'(0);
        2'h1: thr = LVL_W'(2);
        2'h2: thr = LVL_W'(DEPTH / 4);
        default: thr = LVL_W'(DEPTH / 2);
      endcase
      reached = (level <= thr);
    end
  end

endmodule

/* File: hdl/ufc_top.sv */
// uart queue control and interrupt identification with an ahb-lite slave
// assumes level and condition inputs come from the uart datapath, synchronous to hclk
//
// Notes on behaviour
// - read bits 7:6 give 00 off, 11 on
// - receive threshold raises received-data interrupt
// - auto flow drops request-to-send at threshold
// - receive dma request follows receive threshold in mode 1; mode 0 follows not-empty
// - programmable mode raises tx-empty at threshold
// - transmit threshold bits write-only, read zero
// - transmit dma request follows transmit threshold in mode 1; mode 0 follows empty
// - dma mode bit selects mode 0 or 1
// - low four bits report highest pending code
// - transmit reset self-clears, queue appears empty
// - receive reset self-clears, queue appears empty
// - enable change resets both queue controls
// - priority: line, receive/timeout, tx empty, modem
//
// Implementation choice: the AHB-Lite interface to the registers.
module ufc_top #(
  parameter int DEPTH = 16,
  parameter int LVL_W = 5
) (
  // clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // datapath state
  input wire logic [LVL_W-1:0] rx_level,
  input wire logic [LVL_W-1:0] tx_level,
  input wire logic line_status_err,
  input wire logic char_timeout,
  input wire logic busy_detect,
  input wire logic modem_status_chg,
  input wire logic rts_request,
  // queue control
  output logic queues_enable,
  output logic transmit_queue_reset,
  output logic receive_queue_reset,
  // line and dma
  output logic rts_n,
  output logic dma_tx_req_n,
  output logic dma_rx_req_n,
  // interrupt
  output logic irq
);

  logic [1:0] receive_threshold_select_q;
  logic [1:0] transmit_empty_threshold_q;
  logic dma_signal_mode_select_q;
  logic queues_enable_q;
  logic tx_rst_q;
  logic rx_rst_q;
  logic [ufc_pkg::CTRL_W-1:0] ctrl_q;
  logic [ufc_pkg::EV_W-1:0] evt_q;
  logic [ufc_pkg::EV_W-1:0] mask_q;
  logic [ufc_pkg::EV_W-1:0] src_prev_q;
  logic txe_pend_q;
  logic txe_cond_prev_q;
  logic wr_pend_q;
  logic [31:0] wr_addr_q;
  logic [31:0] hrdata_q;
  logic dma_rx_q;
  logic dma_tx_q;
  logic rts_n_q;

  logic addr_ok;
  logic rd_take;
  logic wr_data;
  logic [LVL_W-1:0] rx_eff;
  logic [LVL_W-1:0] tx_eff;
  logic rx_reached;
  logic tx_reached;
  logic txe_cond;
  logic txe_rise;
  logic [ufc_pkg::EV_W-1:0] src;
  logic [3:0] pending_interrupt_code;
  logic [7:0] iir_read;
  logic [31:0] rd_mux;
  logic [7:0] wbyte;
  logic fcr_wr;

  // ahb handshake; stalling while frozen keeps the bus consistent with state
  assign addr_ok = hsel & htrans[ufc_pkg::HTRANS_ACTIVE_BIT] & hready & ce;
  assign rd_take = addr_ok & ~hwrite;
  assign wr_data = wr_pend_q & ce;
  assign hreadyout = ce;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign wbyte = hwdata[7:0];
  assign fcr_wr = wr_data && (wr_addr_q == ufc_pkg::FIFO_CONTROL_INT_IDENT_ADDR);

  // a queue under reset reads as empty to every consumer here
  assign rx_eff = rx_rst_q ? '0 : rx_level;
  assign tx_eff = tx_rst_q ? '0 : tx_level;

  ufc_level_cmp #(
    .DEPTH(DEPTH),
    .LVL_W(LVL_W),
    .IS_TX(1'b0)
  ) u_rx_cmp (
    .level(rx_eff),
    .sel(receive_threshold_select_q),
    .queues_on(queues_enable_q),
    .reached(rx_reached)
  );

  ufc_level_cmp #(
    .DEPTH(DEPTH),
    .LVL_W(LVL_W),
    .IS_TX(1'b1)
  ) u_tx_cmp (
    .level(tx_eff),
    .sel(transmit_empty_threshold_q),
    .queues_on(queues_enable_q),
    .reached(tx_reached)
  );

  // transmit-empty condition: threshold in programmable mode, else plain empty
  always_comb begin
    if (ctrl_q[ufc_pkg::CTRL_PROG_TXE] && queues_enable_q) begin
      txe_cond = tx_reached;
    end else begin
      txe_cond = (tx_eff == '0);
    end
  end
  assign txe_rise = txe_cond & ~txe_cond_prev_q;

  // interrupt sources, gated by their enables; busy detect is never gated
  always_comb begin
    src = '0;
    src[ufc_pkg::EV_RX_DATA] = ctrl_q[ufc_pkg::CTRL_RX_EN] & rx_reached;
    src[ufc_pkg::EV_TX_EMPTY] = ctrl_q[ufc_pkg::CTRL_TXE_EN] & txe_pend_q;
    src[ufc_pkg::EV_LINE] = ctrl_q[ufc_pkg::CTRL_LINE_EN] & line_status_err;
    src[ufc_pkg::EV_TIMEOUT] = ctrl_q[ufc_pkg::CTRL_RX_EN] & char_timeout & queues_enable_q;
    src[ufc_pkg::EV_MODEM] = ctrl_q[ufc_pkg::CTRL_MODEM_EN] & modem_status_chg;
    src[ufc_pkg::EV_BUSY] = busy_detect;
  end

  // highest pending source wins; busy detect ranks last
  always_comb begin
    if (src[ufc_pkg::EV_LINE]) begin
      pending_interrupt_code = ufc_pkg::CODE_LINE;
    end else if (src[ufc_pkg::EV_RX_DATA]) begin
      pending_interrupt_code = ufc_pkg::CODE_RX_DATA;
    end else if (src[ufc_pkg::EV_TIMEOUT]) begin
      pending_interrupt_code = ufc_pkg::CODE_TIMEOUT;
    end else if (src[ufc_pkg::EV_TX_EMPTY]) begin
      pending_interrupt_code = ufc_pkg::CODE_TX_EMPTY;
    end else if (src[ufc_pkg::EV_MODEM]) begin
      pending_interrupt_code = ufc_pkg::CODE_MODEM;
    end else if (src[ufc_pkg::EV_BUSY]) begin
      pending_interrupt_code = ufc_pkg::CODE_BUSY;
    end else begin
      pending_interrupt_code = ufc_pkg::CODE_NONE;
    end
  end

  always_comb begin
    iir_read = '0;
    iir_read[7:6] = queues_enable_q ? ufc_pkg::QSTATUS_ON : ufc_pkg::QSTATUS_OFF;
    iir_read[5:4] = ufc_pkg::TX_THR_READ;
    iir_read[3:0] = pending_interrupt_code;
  end

  // read decode
  always_comb begin
    rd_mux = '0;
    if (haddr == ufc_pkg::FIFO_CONTROL_INT_IDENT_ADDR) begin
      rd_mux[7:0] = iir_read;
    end else if (haddr == ufc_pkg::EVT_STAT_ADDR) begin
      rd_mux[ufc_pkg::EV_W-1:0] = evt_q;
    end else if (haddr == ufc_pkg::EVT_MASK_ADDR) begin
      rd_mux[ufc_pkg::EV_W-1:0] = mask_q;
    end else if (haddr == ufc_pkg::CTRL_ADDR) begin
      rd_mux[ufc_pkg::CTRL_W-1:0] = ctrl_q;
    end else if (haddr == ufc_pkg::LEVEL_ADDR) begin
      rd_mux[LVL_W-1:0] = rx_eff;
      rd_mux[16 +: LVL_W] = tx_eff;
    end else begin
      rd_mux = '0;
    end
  end

  // bus phase tracking and read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
      hrdata_q <= '0;
    end else if (ce) begin
      wr_pend_q <= addr_ok & hwrite;
      if (addr_ok && hwrite) begin
        wr_addr_q <= haddr;
      end
      if (rd_take) begin
        hrdata_q <= rd_mux;
      end
    end
  end

  // queue control fields
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      receive_threshold_select_q <= ufc_pkg::FCR_RESET[ufc_pkg::RX_THR_LSB +: 2];
      transmit_empty_threshold_q <= ufc_pkg::FCR_RESET[ufc_pkg::TX_THR_LSB +: 2];
      dma_signal_mode_select_q <= ufc_pkg::FCR_RESET[ufc_pkg::DMA_MODE_BIT];
      queues_enable_q <= ufc_pkg::FCR_RESET[ufc_pkg::QUEUES_EN_BIT];
    end else if (fcr_wr) begin
      receive_threshold_select_q <= wbyte[ufc_pkg::RX_THR_LSB +: 2];
      transmit_empty_threshold_q <= wbyte[ufc_pkg::TX_THR_LSB +: 2];
      dma_signal_mode_select_q <= wbyte[ufc_pkg::DMA_MODE_BIT];
      queues_enable_q <= wbyte[ufc_pkg::QUEUES_EN_BIT];
    end
  end

  // self-clearing reset pulses, one enabled cycle long
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_rst_q <= 1'b0;
      rx_rst_q <= 1'b0;
    end else if (ce) begin
      tx_rst_q <= fcr_wr && (wbyte[ufc_pkg::XRST_BIT] ||
                  (wbyte[ufc_pkg::QUEUES_EN_BIT] != queues_enable_q));
      rx_rst_q <= fcr_wr && (wbyte[ufc_pkg::RRST_BIT] ||
                  (wbyte[ufc_pkg::QUEUES_EN_BIT] != queues_enable_q));
    end
  end

  // control and mask registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= ufc_pkg::CTRL_RESET;
      mask_q <= ufc_pkg::MASK_RESET;
    end else if (wr_data) begin
      if (wr_addr_q == ufc_pkg::CTRL_ADDR) begin
        ctrl_q <= hwdata[ufc_pkg::CTRL_W-1:0];
      end else if (wr_addr_q == ufc_pkg::EVT_MASK_ADDR) begin
        mask_q <= hwdata[ufc_pkg::EV_W-1:0];
      end
    end
  end

  // pending transmit-empty: armed on each rise, dropped by an identifying read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txe_pend_q <= 1'b0;
      txe_cond_prev_q <= 1'b0;
    end else if (ce) begin
      txe_cond_prev_q <= txe_cond;
      if (txe_rise) begin
        txe_pend_q <= 1'b1;
      end else if (!txe_cond) begin
        txe_pend_q <= 1'b0;
      end else if (rd_take && haddr == ufc_pkg::FIFO_CONTROL_INT_IDENT_ADDR &&
                   pending_interrupt_code == ufc_pkg::CODE_TX_EMPTY) begin
        txe_pend_q <= 1'b0;
      end
    end
  end

  // sticky events on rising source; a new event beats the read-clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_q <= '0;
      src_prev_q <= '0;
    end else if (ce) begin
      src_prev_q <= src;
      if (rd_take && haddr == ufc_pkg::EVT_STAT_ADDR) begin
        evt_q <= src & ~src_prev_q;
      end else begin
        evt_q <= evt_q | (src & ~src_prev_q);
      end
    end
  end

  assign irq = |(evt_q & mask_q);

  // dma requests; mode 1 adds hysteresis between threshold and empty/full
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dma_rx_q <= 1'b0;
      dma_tx_q <= 1'b0;
    end else if (ce) begin
      if (!dma_signal_mode_select_q) begin
        dma_rx_q <= (rx_eff != '0);
        dma_tx_q <= (tx_eff == '0);
      end else begin
        if (rx_reached) begin
          dma_rx_q <= 1'b1;
        end else if (rx_eff == '0) begin
          dma_rx_q <= 1'b0;
        end
        if (tx_reached) begin
          dma_tx_q <= 1'b1;
        end else if (tx_eff == LVL_W'(DEPTH)) begin
          dma_tx_q <= 1'b0;
        end
      end
    end
  end

  // request-to-send, withdrawn at the receive threshold under auto flow
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rts_n_q <= 1'b1;
    end else if (ce) begin
      rts_n_q <= ~rts_request |
                 (ctrl_q[ufc_pkg::CTRL_AUTO_FLOW] & queues_enable_q & rx_reached);
    end
  end

  assign dma_rx_req_n = ~dma_rx_q;
  assign dma_tx_req_n = ~dma_tx_q;
  assign rts_n = rts_n_q;
  assign queues_enable = queues_enable_q;
  assign transmit_queue_reset = tx_rst_q;
  assign receive_queue_reset = rx_rst_q;

endmodule

/* File: bench/ufc_line_model.sv */
// line-side model: fills the receive queue and drains the transmit queue
// assumes the bench sets levels through load; queue resets empty them
module ufc_line_model #(
  parameter int LVL_W = 5
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bench commands
  input wire logic load,
  input wire logic [LVL_W-1:0] rx_set,
  input wire logic [LVL_W-1:0] tx_set,
  // queue resets from the block
  input wire logic transmit_queue_reset,
  input wire logic receive_queue_reset,
  // queue levels
  output logic [LVL_W-1:0] rx_level,
  output logic [LVL_W-1:0] tx_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // a reset pulse wins over a load in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_level <= '0;
    end else if (receive_queue_reset) begin
      rx_level <= '0;
    end else if (load) begin
      rx_level <= rx_set;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_level <= '0;
    end else if (transmit_queue_reset) begin
      tx_level <= '0;
    end else if (load) begin
      tx_level <= tx_set;
    end
  end
endmodule

/* File: bench/ufc_checker.sv */
// concurrent checks on the queue control block ports
// assumes one clock domain, hclk, with async reset hresetn
module ufc_checker #(
  parameter int DEPTH = 16,
  parameter int LVL_W = 5
) (
  // clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // causes
  input wire logic [31:0] hwdata,
  input wire logic rts_request,
  input wire logic [LVL_W-1:0] rx_level,
  input wire logic [LVL_W-1:0] tx_level,
  // effects
  input wire logic queues_enable,
  input wire logic transmit_queue_reset,
  input wire logic receive_queue_reset,
  input wire logic rts_n,
  input wire logic dma_tx_req_n,
  input wire logic dma_rx_req_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_tx_pulse_one: assert property (
    ce && transmit_queue_reset |=> !transmit_queue_reset)
    else $error("transmit queue reset longer than one cycle");
  chk_rx_pulse_one: assert property (
    ce && receive_queue_reset |=> !receive_queue_reset)
    else $error("receive queue reset longer than one cycle");
  chk_tx_pulse_cause: assert property (
    transmit_queue_reset |-> $past(hwdata[2]) || $changed(queues_enable))
    else $error("transmit queue reset without cause");
  chk_rx_pulse_cause: assert property (
    receive_queue_reset |-> $past(hwdata[1]) || $changed(queues_enable))
    else $error("receive queue reset without cause");
  chk_enable_resets: assert property (
    $changed(queues_enable) |-> transmit_queue_reset && receive_queue_reset)
    else $error("enable change did not reset both queues");
  chk_rts_idle: assert property (
    ce && !rts_request |=> rts_n)
    else $error("rts asserted without request");
  chk_rx_dma_empty: assert property (
    ce && rx_level == '0 |=> dma_rx_req_n)
    else $error("receive dma request with empty queue");
  chk_tx_dma_full: assert property (
    ce && tx_level == LVL_W'(DEPTH) && !transmit_queue_reset |=> dma_tx_req_n)
    else $error("transmit dma request with full queue");
endmodule

bind ufc_top ufc_checker #(.DEPTH(DEPTH), .LVL_W(LVL_W)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .ce(ce), .hwdata(hwdata), .rts_request(rts_request),
  .rx_level(rx_level), .tx_level(tx_level), .queues_enable(queues_enable),
  .transmit_queue_reset(transmit_queue_reset), .receive_queue_reset(receive_queue_reset),
  .rts_n(rts_n), .dma_tx_req_n(dma_tx_req_n), .dma_rx_req_n(dma_rx_req_n)
);

/* File: bench/tb_top.sv */
// self-checking bench: ahb-lite master, line model and scenario tasks
// assumes zero-wait slave but bounds every wait anyway
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] A_IIR = ufc_pkg::FIFO_CONTROL_INT_IDENT_ADDR;
  localparam logic [31:0] A_STA = ufc_pkg::EVT_STAT_ADDR;
  localparam logic [31:0] A_MSK = ufc_pkg::EVT_MASK_ADDR;
  localparam logic [31:0] A_CTL = ufc_pkg::CTRL_ADDR;
  logic hclk, hresetn, ce, hsel, hwrite, load, rts_request;
  logic line_status_err, char_timeout, busy_detect, modem_status_chg;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [4:0] rx_set, tx_set, rx_level, tx_level;
  logic hreadyout, hresp, queues_enable, transmit_queue_reset, receive_queue_reset;
  logic rts_n, dma_tx_req_n, dma_rx_req_n, irq;
  wire logic hready;
  int err_total, compares;
  assign hready = hreadyout;
  ufc_top DUT (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .rx_level(rx_level), .tx_level(tx_level),
    .line_status_err(line_status_err), .char_timeout(char_timeout), .busy_detect(busy_detect),
    .modem_status_chg(modem_status_chg), .rts_request(rts_request),
    .transmit_queue_reset(transmit_queue_reset), .receive_queue_reset(receive_queue_reset),
    .queues_enable(queues_enable), .rts_n(rts_n), .dma_tx_req_n(dma_tx_req_n),
    .dma_rx_req_n(dma_rx_req_n), .irq(irq)
  );
  ufc_line_model u_line (
    .hclk(hclk), .hresetn(hresetn), .load(load), .rx_set(rx_set), .tx_set(tx_set),
    .transmit_queue_reset(transmit_queue_reset), .receive_queue_reset(receive_queue_reset),
    .rx_level(rx_level), .tx_level(tx_level)
  );

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  task automatic end_sim();
    if (err_total == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) begin
      err_total++;
      end_sim();
    end
  endtask

  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    v = hrdata;
  endtask

  // levels land one edge after load; dma and receive status need one more, tx-empty status two
  task automatic lvl(input logic [4:0] r, input logic [4:0] t);
    load <= 1'b1;
    rx_set <= r;
    tx_set <= t;
    @(posedge hclk);
    load <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask

  task automatic t_reset();
    bus(0, A_IIR, 0);
    chk(v, 32'h01);
    chk({hresp, rts_n, dma_tx_req_n, dma_rx_req_n, irq, queues_enable}, 6'h14);
    bus(0, A_CTL, 0);
    chk(v, 32'h00);
    bus(0, A_MSK, 0);
    chk(v, 32'h00);
    bus(1, 32'h5000_1190, 32'hffff_ffff);
    bus(0, 32'h5000_1190, 0);
    chk(v, 32'h00);
  endtask

  task automatic t_enable();
    lvl(3, 5);
    bus(1, A_IIR, 32'h31);
    #1;
    chk({transmit_queue_reset, receive_queue_reset, queues_enable}, 3'h7);
    bus(0, A_IIR, 0);
    chk(v & 32'hf0, 32'hc0);
    chk(rx_level, 5'h00);
  endtask

  task automatic t_resets();
    for (int i = 0; i < 2; i++) begin
      bus(1, A_IIR, 32'h31 | (32'h4 >> i));
      #1;
      chk({transmit_queue_reset, receive_queue_reset}, i ? 2'h1 : 2'h2);
      @(posedge hclk);
      #1;
      chk({transmit_queue_reset, receive_queue_reset}, 2'h0);
    end
  endtask

  task automatic t_rx_irq();
    bus(1, A_CTL, 32'h01);
    bus(1, A_MSK, 32'h01);
    bus(1, A_IIR, 32'h41);
    lvl(3, 5);
    chk(irq, 1'b0);
    lvl(4, 5);
    chk(irq, 1'b1);
    bus(0, A_IIR, 0);
    chk(v & 32'hf, 32'h4);
    bus(1, A_MSK, 32'h00);
    @(posedge hclk);
    chk(irq, 1'b0);
    bus(1, A_MSK, 32'h01);
    @(posedge hclk);
    chk(irq, 1'b1);
    bus(0, A_STA, 0);
    chk(v & 32'h1, 32'h1);
    @(posedge hclk);
    chk(irq, 1'b0);
  endtask

  task automatic t_prio();
    bus(1, A_CTL, 32'h05);
    line_status_err <= 1'b1;
    repeat (3) @(posedge hclk);
    bus(0, A_IIR, 0);
    chk(v & 32'hf, 32'h6);
    line_status_err <= 1'b0;
    repeat (3) @(posedge hclk);
    bus(0, A_IIR, 0);
    chk(v & 32'hf, 32'h4);
    lvl(0, 5);
    busy_detect <= 1'b1;
    repeat (3) @(posedge hclk);
    bus(0, A_IIR, 0);
    chk(v & 32'hf, 32'h7);
    busy_detect <= 1'b0;
    repeat (3) @(posedge hclk);
    bus(0, A_IIR, 0);
    chk(v & 32'hf, 32'h1);
    bus(1, A_CTL, 32'h0d);
    char_timeout <= 1'b1;
    modem_status_chg <= 1'b1;
    repeat (3) @(posedge hclk);
    bus(0, A_IIR, 0);
    chk(v & 32'hf, 32'hc);
    char_timeout <= 1'b0;
    repeat (3) @(posedge hclk);
    bus(0, A_IIR, 0);
    chk(v & 32'hf, 32'h0);
    modem_status_chg <= 1'b0;
  endtask

  task automatic t_txe();
    bus(1, A_CTL, 32'h12);
    bus(1, A_IIR, 32'h11);
    lvl(0, 3);
    bus(0, A_IIR, 0);
    chk(v & 32'hf, 32'h1);
    lvl(0, 2);
    bus(0, A_IIR, 0);
    chk(v & 32'hf, 32'h2);
    bus(0, A_IIR, 0);
    chk(v & 32'hf, 32'h1);
  endtask

  task automatic t_dma_rts();
    bus(1, A_CTL, 32'h00);
    bus(1, A_IIR, 32'h41);
    lvl(2, 0);
    chk({dma_rx_req_n, dma_tx_req_n}, 2'h0);
    lvl(0, 16);
    chk({dma_rx_req_n, dma_tx_req_n}, 2'h3);
    bus(1, A_IIR, 32'h49);
    lvl(2, 16);
    chk(dma_rx_req_n, 1'b1);
    lvl(4, 0);
    chk({dma_rx_req_n, dma_tx_req_n}, 2'h0);
    lvl(4, 5);
    chk(dma_tx_req_n, 1'b0);
    lvl(4, 16);
    chk(dma_tx_req_n, 1'b1);
    bus(0, ufc_pkg::LEVEL_ADDR, 0);
    chk(v, 32'h0010_0004);
    bus(1, A_CTL, 32'h20);
    rts_request <= 1'b1;
    lvl(0, 0);
    chk(rts_n, 1'b0);
    lvl(4, 0);
    chk(rts_n, 1'b1);
    // frozen while ce is low: no bus answer, rts_n holds its old level
    ce <= 1'b0;
    lvl(0, 0);
    chk({hreadyout, rts_n}, 2'h1);
    ce <= 1'b1;
    repeat (2) @(posedge hclk);
    chk(rts_n, 1'b0);
  endtask

  initial begin
    err_total = 0;
    compares = 0;
    hresetn = 1'b0;
    ce = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    load = 1'b0;
    rx_set = 5'h0;
    tx_set = 5'h0;
    rts_request = 1'b0;
    line_status_err = 1'b0;
    char_timeout = 1'b0;
    busy_detect = 1'b0;
    modem_status_chg = 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_enable();
    t_resets();
    t_rx_irq();
    t_prio();
    t_txe();
    t_dma_rts();
    end_sim();
  end
endmodule
